//--- hw/rac_alarm_ctrl.sv
// What this block does
// - Alarm one 07h-0Ah, alarm two 0Bh-0Dh.
// - Bit 7 masks field; unmasked fields must equal.
// - Bit 6 picks date (0) or weekday (1).
// - Match sets that alarm's flag.
// - Pin asserts when flag, enable and select.
// - Matches checked only on second update.
// - Alarm one mask table sets repeat rate.
// - Alarm two table; seconds always zero.
// - Oscillator stops only on battery when disabled.
// - Pin floats below the trip point unless enabled.
// - Convert write starts conversion only when idle.
// - Convert reads one until conversion completes.
// - Busy unaffected about 2ms after forcing.
// - Rate bits select 1Hz to 8.192kHz.
// - Select zero gives wave, one gives interrupt.
// - Flags set regardless of enables.
// - Control powers up with 0x1c.
// - Status register bit layout as given.
// - Active alarm interrupt drives pin low.
// - Flags clear only by writing zero.
// - Busy follows sensor conversion signal.
`include "rac_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rac_alarm_ctrl #(
  parameter int BUSY_DLY_CYC = `RAC_BUSY_DLY_US * `RAC_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire rac_pkg::rac_req_s req,
  output logic [7:0] reg_rdata,
  input wire rac_pkg::rac_time_s time_now,
  input wire logic sec_tick,
  input wire logic ref_clk_in,
  input wire logic on_battery_in,
  input wire logic below_trip_in,
  input wire logic sensor_busy,
  input wire logic sensor_done,
  output logic force_temp_conversion_start,
  output logic osc_enable,
  output logic [1:0] force_temp_conversion_rate,
  output logic khz_out_enable,
  output logic battery_khz_out_enable,
  output logic irq_wave_pin_o,
  output logic irq_wave_pin_oe
);
  import rac_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // A field matches when it is masked or equal to the running value.
  function automatic logic fld_ok(input logic [7:0] a, input logic [7:0] t);
    fld_ok = a[`RAC_MASK_BIT] | (a[6:0] == t[6:0]);
  endfunction : fld_ok

  // The day/date byte compares weekday or date by its selector.
  function automatic logic dd_ok(input logic [7:0] a, input rac_time_s t);
    if (a[`RAC_DYDT_BIT]) begin
      dd_ok = a[`RAC_MASK_BIT] | (a[3:0] == t.day[3:0]);
    end else begin
      dd_ok = a[`RAC_MASK_BIT] | (a[5:0] == t.date[5:0]);
    end
  endfunction : dd_ok

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each before anything reads them.

  logic [2:0] meta_q; // First stage, read only by the second.
  logic [2:0] sync_q; // Second stage: reference clock, battery, trip.
  logic ref_prev_q; // Previous reference level for edge finding.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      ref_prev_q <= 1'b0;
    end else begin
      meta_q <= {below_trip_in, on_battery_in, ref_clk_in};
      sync_q <= meta_q;
      ref_prev_q <= sync_q[0];
    end
  end
  logic on_batt; // Running from the backup supply.
  logic below_trip; // Main supply below the power-fail point.
  logic ref_rise; // One rising edge of the reference clock.
  assign on_batt = sync_q[1];
  assign below_trip = sync_q[2];
  assign ref_rise = sync_q[0] & ~ref_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // Register storage and next values.

  logic [7:0] alm_q [0:6]; // Alarm bytes, index 0 at the first alarm seconds.
  logic [7:0] alm_d [0:6];
  logic [7:0] ctrl_q; // Control register.
  logic [7:0] ctrl_d;
  logic [7:0] stat_q; // Status register; busy is live.
  logic [7:0] stat_d;
  logic [7:0] rdata_d;
  logic [14:0] div_q; // Reference edge counter for the square wave.
  logic [14:0] div_d;
  logic tick; // Second update, frozen while the oscillator is stopped.
  logic match1; // First alarm matches the new time.
  logic match2; // Second alarm matches the new time.
  logic wr_ctl; // Host writes the control register.
  logic wr_stat; // Host writes the status register.
  rac_force_temp_conversion_e force_temp_conversion_q; // Forced conversion state.
  rac_force_temp_conversion_e force_temp_conversion_d;
  logic [17:0] dly_q; // Cycles spent holding before the sensor request.
  logic [17:0] dly_d;

  assign osc_enable = ~(ctrl_q[`RAC_C_OSC_DISABLE_ON_BATTERY] & on_batt);
  assign tick = sec_tick & osc_enable;
  assign wr_ctl = req.wr & (req.addr == `RAC_CTRL);
  assign wr_stat = req.wr & (req.addr == `RAC_STAT);

  // Alarm one compares seconds, minutes, hours and day/date.
  assign match1 = fld_ok(alm_q[0], time_now.sec) & fld_ok(alm_q[1], time_now.min)
    & fld_ok(alm_q[2], time_now.hour) & dd_ok(alm_q[3], time_now);
  // Alarm two has no seconds byte and fires only at zero seconds.
  assign match2 = (time_now.sec == 8'h00) & fld_ok(alm_q[4], time_now.min)
    & fld_ok(alm_q[5], time_now.hour) & dd_ok(alm_q[6], time_now);

  // Next values of every host-visible byte, including flag setting and reads.
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      alm_d[i] = alm_q[i];
      // Alarm bytes sit from the first alarm's seconds upward.
      if (req.wr && (req.addr == (`RAC_A1_FIRST + 8'(i)))) begin
        alm_d[i] = req.wdata;
      end
    end
    ctrl_d = ctrl_q;
    if (wr_ctl) begin
      ctrl_d = req.wdata;
      ctrl_d[`RAC_C_FORCE_TEMP_CONVERSION] = 1'b0; // The convert bit lives in the sequencer.
    end
    stat_d = stat_q;
    if (wr_stat) begin
      // Flags and the stop flag only take a written zero.
      stat_d[`RAC_S_OSF] = stat_q[`RAC_S_OSF] & req.wdata[`RAC_S_OSF];
      stat_d[`RAC_S_BBK] = req.wdata[`RAC_S_BBK];
      stat_d[`RAC_S_CR1] = req.wdata[`RAC_S_CR1];
      stat_d[`RAC_S_CR0] = req.wdata[`RAC_S_CR0];
      stat_d[`RAC_S_KHZ] = req.wdata[`RAC_S_KHZ];
      stat_d[`RAC_S_F2] = stat_q[`RAC_S_F2] & req.wdata[`RAC_S_F2];
      stat_d[`RAC_S_F1] = stat_q[`RAC_S_F1] & req.wdata[`RAC_S_F1];
    end
    stat_d[`RAC_S_BSY] = 1'b0;
    // Hardware sets after the clear so a same-cycle event survives.
    if (!osc_enable) begin
      stat_d[`RAC_S_OSF] = 1'b1;
    end
    if (tick && match1) begin
      stat_d[`RAC_S_F1] = 1'b1;
    end
    if (tick && match2) begin
      stat_d[`RAC_S_F2] = 1'b1;
    end
    rdata_d = reg_rdata;
    if (req.rd) begin
      rdata_d = 8'h00;
      if ((req.addr >= `RAC_A1_FIRST) && (req.addr <= `RAC_A2_LAST)) begin
        rdata_d = alm_q[3'(req.addr - `RAC_A1_FIRST)];
      end else if (req.addr == `RAC_CTRL) begin
        rdata_d = ctrl_q;
        // While running, the convert bit tracks busy so that both fall together.
        rdata_d[`RAC_C_FORCE_TEMP_CONVERSION] = (force_temp_conversion_q == RAC_HOLD)
          | ((force_temp_conversion_q == RAC_RUN) & sensor_busy);
      end else if (req.addr == `RAC_STAT) begin
        rdata_d = stat_q;
        rdata_d[`RAC_S_BSY] = sensor_busy;
      end
    end
    div_d = ref_rise ? (div_q + 15'h0001) : div_q;
  end

  // Register every byte; reset gives the power-up values.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 7; i++) begin
        alm_q[i] <= 8'h00;
      end
      ctrl_q <= `RAC_CTRL_RST;
      stat_q <= `RAC_STAT_RST;
      reg_rdata <= 8'h00;
      div_q <= 15'h0000;
    end else begin
      for (int i = 0; i < 7; i++) begin
        alm_q[i] <= alm_d[i];
      end
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      reg_rdata <= rdata_d;
      div_q <= div_d;
    end
  end

  assign force_temp_conversion_rate = {stat_q[`RAC_S_CR1], stat_q[`RAC_S_CR0]};
  assign khz_out_enable = stat_q[`RAC_S_KHZ];
  assign battery_khz_out_enable = stat_q[`RAC_S_BBK];

  //////////////////////////////////////////////////////////////////////////////
  // Forced temperature conversion.

  // A request is taken only when idle and the sensor is not converting, then
  // held for the busy delay so an early busy read sees the old state.
  always_comb begin
    force_temp_conversion_d = force_temp_conversion_q;
    dly_d = dly_q;
    force_temp_conversion_start = 1'b0;
    case (force_temp_conversion_q)
      RAC_IDLE: begin
        dly_d = 18'h00000;
        if (wr_ctl && req.wdata[`RAC_C_FORCE_TEMP_CONVERSION] && !sensor_busy) begin
          force_temp_conversion_d = RAC_HOLD;
        end
      end
      RAC_HOLD: begin
        dly_d = dly_q + 18'h00001;
        if (dly_q == 18'(BUSY_DLY_CYC - 1)) begin
          force_temp_conversion_start = 1'b1;
          force_temp_conversion_d = RAC_RUN;
        end
      end
      RAC_RUN: begin
        if (sensor_done) begin
          force_temp_conversion_d = RAC_IDLE;
        end
      end
      default: begin
        force_temp_conversion_d = RAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_temp_conversion_q <= RAC_IDLE;
      dly_q <= 18'h00000;
    end else begin
      force_temp_conversion_q <= force_temp_conversion_d;
      dly_q <= dly_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared interrupt and square-wave pin, open drain and active low.

  logic wave; // Selected square wave.
  logic irq_act; // An enabled alarm flag is pending.
  logic pin_off; // Main supply below trip without pin enable: pin floats.
  always_comb begin
    case ({ctrl_q[`RAC_C_RS2], ctrl_q[`RAC_C_RS1]})
      2'b00: wave = div_q[`RAC_TAP_1HZ];
      2'b01: wave = div_q[`RAC_TAP_1K];
      2'b10: wave = div_q[`RAC_TAP_4K];
      default: wave = div_q[`RAC_TAP_8K];
    endcase
  end
  assign irq_act = (stat_q[`RAC_S_F1] & ctrl_q[`RAC_C_IE1])
    | (stat_q[`RAC_S_F2] & ctrl_q[`RAC_C_IE2]);
  assign pin_off = below_trip & ~ctrl_q[`RAC_C_BBW];
  assign irq_wave_pin_o = 1'b0;
  // Drive low for an alarm in interrupt mode, or for the wave's low half.
  assign irq_wave_pin_oe = ~pin_off & (ctrl_q[`RAC_C_SEL] ? irq_act : ~wave);

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence force_taken;
    wr_ctl && req.wdata[`RAC_C_FORCE_TEMP_CONVERSION] && !sensor_busy && (force_temp_conversion_q == RAC_IDLE);
  endsequence
  sequence quiet_hold;
    (!force_temp_conversion_start && (force_temp_conversion_q == RAC_HOLD)) [*8];
  endsequence

  flag_set_a: assert property (tick && match1 |=> stat_q[`RAC_S_F1])
    else $error("alarm one flag not set on match");
  flag_set_any_a: assert property (tick && match2 && !ctrl_q[`RAC_C_IE2] |=> stat_q[`RAC_S_F2])
    else $error("alarm two flag not set while disabled");
  flag_tick_a: assert property ($rose(stat_q[`RAC_S_F1]) |-> $past(tick))
    else $error("alarm flag rose without second update");
  flag_hold_a: assert property (stat_q[`RAC_S_F2] && !(wr_stat && !req.wdata[`RAC_S_F2])
    |=> stat_q[`RAC_S_F2])
    else $error("alarm flag cleared without a zero write");
  irq_pin_a: assert property (ctrl_q[`RAC_C_SEL] && stat_q[`RAC_S_F1] && ctrl_q[`RAC_C_IE1]
    && !pin_off |-> irq_wave_pin_oe)
    else $error("pin not low for enabled alarm");
  irq_gate_a: assert property (ctrl_q[`RAC_C_SEL] && !irq_act |-> !irq_wave_pin_oe)
    else $error("pin low without enabled alarm");
  wave_pin_a: assert property (!ctrl_q[`RAC_C_SEL] && !pin_off |-> irq_wave_pin_oe == !wave)
    else $error("pin does not follow square wave");
  pin_float_a: assert property (pin_off |-> !irq_wave_pin_oe)
    else $error("pin driven while it must float");
  osc_gate_a: assert property (ctrl_q[`RAC_C_OSC_DISABLE_ON_BATTERY] && on_batt |=> stat_q[`RAC_S_OSF])
    else $error("oscillator stop not flagged on battery");
  force_temp_conversion_busy_a: assert property (wr_ctl && req.wdata[`RAC_C_FORCE_TEMP_CONVERSION] && sensor_busy
    && (force_temp_conversion_q == RAC_IDLE) |=> force_temp_conversion_q == RAC_IDLE)
    else $error("forced conversion taken while busy");
  force_temp_conversion_hold_a: assert property (force_taken |=> quiet_hold)
    else $error("sensor requested before busy delay");
  force_temp_conversion_done_a: assert property ((force_temp_conversion_q == RAC_RUN) && sensor_done |=> force_temp_conversion_q == RAC_IDLE)
    else $error("convert bit not cleared at completion");
endmodule : rac_alarm_ctrl
`default_nettype wire

//--- hw/rac_map.svh
`ifndef RAC_MAP_SVH
`define RAC_MAP_SVH
// Register offsets.
`define RAC_A1_FIRST 8'h07
`define RAC_A1_LAST 8'h0a
`define RAC_A2_FIRST 8'h0b
`define RAC_A2_LAST 8'h0d
`define RAC_CTRL 8'h0e
`define RAC_STAT 8'h0f
// Reset values.
`define RAC_CTRL_RST 8'h1c
`define RAC_STAT_RST 8'hc8
// Field positions shared by the alarm bytes.
`define RAC_MASK_BIT 7
`define RAC_DYDT_BIT 6
// Control bit positions.
`define RAC_C_OSC_DISABLE_ON_BATTERY 7
`define RAC_C_BBW 6
`define RAC_C_FORCE_TEMP_CONVERSION 5
`define RAC_C_RS2 4
`define RAC_C_RS1 3
`define RAC_C_SEL 2
`define RAC_C_IE2 1
`define RAC_C_IE1 0
// Status bit positions.
`define RAC_S_OSF 7
`define RAC_S_BBK 6
`define RAC_S_CR1 5
`define RAC_S_CR0 4
`define RAC_S_KHZ 3
`define RAC_S_BSY 2
`define RAC_S_F2 1
`define RAC_S_F1 0
// Timing.
`define RAC_CLK_MHZ 100
`define RAC_BUSY_DLY_US 2000
// Divider taps on the reference edge counter for each wave rate.
`define RAC_TAP_1HZ 14
`define RAC_TAP_1K 4
`define RAC_TAP_4K 2
`define RAC_TAP_8K 1
`endif

//--- hw/rac_pkg.sv
package rac_pkg;
  // Timekeeping values after the once-per-second update, BCD as stored.
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] date;
  } rac_time_s;
  // Register access strobes with address and data.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rac_req_s;
  // Forced conversion sequencer states.
  typedef enum logic [2:0] {
    RAC_IDLE = 3'b001,
    RAC_HOLD = 3'b010,
    RAC_RUN = 3'b100
  } rac_force_temp_conversion_e;
endpackage : rac_pkg

//--- verif/rac_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
// Temperature sensor stand-in on the far side of the conversion handshake.
module rac_sensor_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] lat,
  input wire logic force_temp_conversion_start,
  output logic sensor_busy,
  output logic sensor_done
);
  // Cycles left in the running conversion.
  logic [7:0] cnt_q;
  // A request raises busy; lat+1 cycles later busy drops with a one-cycle done pulse.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sensor_busy <= 1'b0;
      sensor_done <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      sensor_done <= 1'b0;
      if (force_temp_conversion_start) begin
        sensor_busy <= 1'b1;
        cnt_q <= lat;
      end else if (sensor_busy && cnt_q == 8'h00) begin
        sensor_busy <= 1'b0;
        sensor_done <= 1'b1;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : rac_sensor_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "rac_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %0t: value mismatch", $time); end end
module testbench;
  import rac_pkg::*;
  localparam int DLY = 20;
  logic sys_clk = 0, rst_n = 0, ref_clk_in = 0, on_battery_in = 0, below_trip_in = 0;
  logic sec_tick = 0, force_temp_conversion_start, osc_enable, khz, bbk, pin_o, oe, busy, done, e1, e2;
  rac_req_s req = '0;
  rac_time_s time_now = '0;
  logic [7:0] reg_rdata, d, w, a[7:13];
  logic [1:0] force_temp_conversion_rate, f_m = 2'b00;
  logic [31:0] seed = 32'h8441, r, q;
  logic [3:0] ev, mid_m = 4'h9;
  logic osf_m = 1'b1;
  // Listed mask combinations only, daydate bit first.
  logic [3:0] m1[6] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h0, 4'h0};
  logic [2:0] m2[5] = '{3'h7, 3'h6, 3'h4, 3'h0, 3'h0};
  int tap[4] = '{`RAC_TAP_1HZ, `RAC_TAP_1K, `RAC_TAP_4K, `RAC_TAP_8K};
  int err_count = 0, num_checks = 0, k, starts = 0;
  initial forever #5 sys_clk = ~sys_clk;
  // Reference clock, 80 ns period, offset from the system clock.
  initial begin
    #3;
    forever #40 ref_clk_in = ~ref_clk_in;
  end
  rac_alarm_ctrl #(.BUSY_DLY_CYC(DLY)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
    .reg_rdata(reg_rdata), .time_now(time_now), .sec_tick(sec_tick), .ref_clk_in(ref_clk_in),
    .on_battery_in(on_battery_in), .below_trip_in(below_trip_in), .sensor_busy(busy),
    .sensor_done(done), .force_temp_conversion_start(force_temp_conversion_start), .osc_enable(osc_enable),
    .force_temp_conversion_rate(force_temp_conversion_rate), .khz_out_enable(khz), .battery_khz_out_enable(bbk),
    .irq_wave_pin_o(pin_o), .irq_wave_pin_oe(oe));
  rac_sensor_model sen (.sys_clk(sys_clk), .rst_n(rst_n), .lat(8'd30),
    .force_temp_conversion_start(force_temp_conversion_start), .sensor_busy(busy), .sensor_done(done));
  // Counts conversion requests seen at the sensor.
  always @(posedge sys_clk) if (force_temp_conversion_start) starts <= starts + 1;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  // Expected status byte from the bench model.
  function automatic logic [7:0] st_e();
    return {osf_m, mid_m, busy, f_m};
  endfunction : st_e
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    req = '{1'b1, 1'b0, ad, v};
    step();
    req.wr = 1'b0;
    step();
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    req = '{1'b0, 1'b1, ad, 8'h00};
    step();
    req.rd = 1'b0;
    step();
    v = reg_rdata;
  endtask : rd
  // Status write; the model keeps flags and the stop flag clear-only.
  task automatic wst(input logic [7:0] v);
    wr(8'h0f, v);
    osf_m = osf_m & v[7];
    mid_m = v[6:3];
    f_m = f_m & v[1:0];
  endtask : wst
  // Cycles between two pin edges, or lim when the pin stays still.
  task automatic meas(input int lim, output int n);
    logic p;
    n = 0;
    p = oe;
    while (oe === p && n < lim) begin step(); n++; end
    p = oe;
    n = 0;
    while (oe === p && n < lim) begin step(); n++; end
  endtask : meas
  initial begin
    #500us;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    step();
    step();
    rd(8'h0e, d); `CHK(d, 8'h1c)
    rd(8'h0f, d); `CHK(d, st_e())
    rd(8'h10, d); `CHK(d, 8'h00)
    `CHK({oe, pin_o}, 2'b00)
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      r = seed;
      seed = xs(seed);
      q = seed;
      a[7] = {m1[i % 6][0], 1'b0, r[5:0]};
      a[8] = {m1[i % 6][1], 1'b0, r[13:8]};
      a[9] = {m1[i % 6][2], r[22:16]};
      a[10] = {m1[i % 6][3], q[8], r[29:24]};
      a[11] = {m2[i % 5][0], a[8][6:0]};
      a[12] = {m2[i % 5][1], a[9][6:0]};
      a[13] = {m2[i % 5][2], a[10][6:0]};
      for (int j = 7; j < 14; j++) wr(j[7:0], a[j]);
      time_now = '{q[9] ? 8'h00 : {1'b0, a[7][6:0]}, {1'b0, a[8][6:0]},
        {1'b0, a[9][6:0]}, {4'h0, a[10][3:0]}, {2'b00, a[10][5:0]}};
      if (q[10]) time_now = time_now ^ (40'h1 << (8 * (q[13:11] % 5)));
      ev[0] = time_now.sec[6:0] == a[7][6:0];
      ev[1] = time_now.min[6:0] == a[8][6:0];
      ev[2] = time_now.hour[6:0] == a[9][6:0];
      ev[3] = a[10][6] ? time_now.day[3:0] == a[10][3:0] : time_now.date[5:0] == a[10][5:0];
      e1 = &(m1[i % 6] | ev);
      e2 = (time_now.sec == 8'h00) & (&(m2[i % 5] | ev[3:1]));
      w = {5'b00000, 1'b1, q[1:0]};
      wr(8'h0e, w);
      wst({q[7:3], 3'b000});
      `CHK({bbk, force_temp_conversion_rate, khz}, q[6:3])
      rd(8'h0f, d); `CHK(d, st_e())
      sec_tick = 1'b1;
      step();
      sec_tick = 1'b0;
      step();
      f_m = {e2, e1};
      rd(8'h0f, d); `CHK(d, st_e())
      `CHK(oe, |(f_m & w[1:0]))
      wst({q[7:3], 1'b0, q[15:14]});
      rd(8'h0f, d); `CHK(d, st_e())
      wst({q[7:3], 3'b000});
    end
    rd(8'h0f, d); `CHK(d[2], 1'b0)
    wr(8'h0e, 8'h24);
    rd(8'h0e, d); `CHK(d[5], 1'b1)
    rd(8'h0f, d); `CHK(d[2], 1'b0)
    // Busy must stay low for the whole hold, counted in cycles from the write edge.
    k = 5;
    while (busy !== 1'b1 && k < 200) begin step(); k++; end
    `CHK(k, DLY)
    if (busy !== 1'b1) begin err_count++; finish_test(); end
    step();
    step();
    rd(8'h0f, d); `CHK(d[2], 1'b1)
    wr(8'h0e, 8'h24);
    rd(8'h0e, d); `CHK(d[5], 1'b1)
    // Follow the forced conversion by its convert bit, as a host would.
    k = 0;
    do begin rd(8'h0e, d); k++; end while (d[5] === 1'b1 && k < 100);
    if (d[5] !== 1'b0) begin err_count++; finish_test(); end
    `CHK(d, 8'h04)
    rd(8'h0f, d); `CHK(d[2], 1'b0)
    `CHK(starts, 1)
    on_battery_in = 1'b1;
    wr(8'h0e, 8'h84);
    repeat (4) step();
    `CHK(osc_enable, 1'b0)
    rd(8'h0f, d); `CHK(d[7], 1'b1)
    wr(8'h0e, 8'h04);
    repeat (4) step();
    `CHK(osc_enable, 1'b1)
    on_battery_in = 1'b0;
    wr(8'h0e, 8'h84);
    repeat (4) step();
    `CHK(osc_enable, 1'b1)
    for (int s = 0; s < 4; s++) begin
      wr(8'h0e, {3'b000, s[1:0], 3'b000});
      meas(1500, k);
      `CHK(k, s == 0 ? 1500 : 8 << tap[s])
    end
    below_trip_in = 1'b1;
    repeat (4) step();
    meas(100, k);
    `CHK(k, 100)
    `CHK(oe, 1'b0)
    wr(8'h0e, 8'h58);
    meas(100, k);
    `CHK(k, 16)
    below_trip_in = 1'b0;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
